// ---- design/sensor_cmd_consts.svh ----
// constants for the sensor command and enable controller
`ifndef SENSOR_CMD_CONSTS_SVH
`define SENSOR_CMD_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_FUNCTION_ENABLE   5'h00
`define OFS_LIGHT_INTEG_TIME  5'h01

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_FUNCTION_ENABLE   8'h00
`define RST_LIGHT_INTEG_TIME  8'hff

// ----------------------------------------
// command byte fields
// ----------------------------------------
`define CMD_SELECT_BIT        7
`define CMD_TYPE_HI           6
`define CMD_TYPE_LO           5
`define CMD_ADDR_HI           4

// ----------------------------------------
// special function codes
// ----------------------------------------
`define SF_NO_ACTION          5'h00
`define SF_CLEAR_PROX         5'h05
`define SF_CLEAR_LIGHT        5'h06
`define SF_CLEAR_BOTH         5'h07

// ----------------------------------------
// function enable bit positions
// ----------------------------------------
`define EN_SLEEP_AFTER_IRQ    6
`define EN_PROX_IRQ_MASK      5
`define EN_LIGHT_IRQ_MASK     4
`define EN_WAIT_TIMER         3
`define EN_PROX_FUNCTION      2
`define EN_LIGHT_CONVERTER    1
`define EN_OSCILLATOR         0

// ----------------------------------------
// timing and counts
// ----------------------------------------
`define CLK_PERIOD_NS         4
`define STEP_TIME_NS          2730000
`define STEP_COUNT_LIMIT      1024
`define RESULT_SATURATE       65535
`define TOTAL_STEP_BASE       256

`endif

// ---- design/sensor_cmd_pkg.sv ----
// types shared by the sensor command and enable controller
package sensor_cmd_pkg;

  // ----------------------------------------
  // transaction types from the command byte
  // ----------------------------------------
  typedef enum logic [1:0] {
    XFER_REPEAT  = 2'h0,
    XFER_AUTOINC = 2'h1,
    XFER_RESV    = 2'h2,
    XFER_SPECIAL = 2'h3
  } xfer_type_t;

  // ----------------------------------------
  // serial target states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SER_IDLE,
    SER_ADDR,
    SER_ACK,
    SER_WRBYTE,
    SER_RDBYTE,
    SER_RDACK
  } ser_state_t;

endpackage : sensor_cmd_pkg

// ---- design/sensor_command_enable_ctrl.sv ----
// command decoder, enable register and light integration timing
//
// What this block does
// - type 00 keeps the same register selected.
// - type 01 advances pointer after each byte.
// - type 11 makes low field special code.
// - codes clear proximity, light, or both interrupts.
// - interrupt clear acts once, stores nothing.
// - sleep-after-interrupt powers down after interrupt cycle.
// - proximity interrupts only while its mask set.
// - light interrupts only while its mask set.
// - enable bit 3 runs the wait timer.
// - enable bit 2 runs proximity function.
// - enable bit 1 runs light converter.
// - bit 0 runs oscillator; others need it.
// - integration is 256 minus value steps.
// - integration time resets to 0xff.
`timescale 1ns/1ps
`include "sensor_cmd_consts.svh"
module sensor_command_enable_ctrl
  import sensor_cmd_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2a,  // arbitrary bus address
  parameter int         STEP_CYCLES = `STEP_TIME_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial port pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOe_n,
  // analog side events, same clock
  input  wire logic [10:0] lightStepCounts,
  input  wire logic        lightOutOfRange,
  input  wire logic        proxCycleDone,
  input  wire logic        proxOutOfRange,
  // function controls
  output logic             oscillatorOn,
  output logic             lightConverterOn,
  output logic             proxFunctionOn,
  output logic             waitTimerOn,
  // results and interrupts
  output logic             lightCycleDone,
  output logic [15:0]      lightResult,
  output logic             proxIrqPending,
  output logic             lightIrqPending,
  output logic             irqActive
);

  // ----------------------------------------
  // serial target
  // ----------------------------------------
  logic       byteValid;   // one written byte arrived
  logic       byteFirst;   // it is the command byte
  logic [7:0] byteData;
  logic       readLoad;    // target took readData
  logic [7:0] readData;

  serial_target #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_serial (
    .clk       (clk),
    .rst_n     (rst_n),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .sdaOe_n   (sdaOe_n),
    .byteValid (byteValid),
    .byteFirst (byteFirst),
    .byteData  (byteData),
    .readLoad  (readLoad),
    .readData  (readData)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0]  enable_reg, enable_next;        // function enable
  logic [7:0]  integ_reg, integ_next;          // light integration time
  logic [4:0]  pointer_reg, pointer_next;      // selected register
  xfer_type_t  xfer_reg, xfer_next;            // access mode
  logic        proxPend_reg, proxPend_next;    // pending interrupts
  logic        lightPend_reg, lightPend_next;
  logic        irq_reg, irq_next;
  logic [3:0]  gated_reg, gated_next;          // outputs gated by oscillator
  logic        clearProx, clearLight;          // special function this cycle
  logic        cycleEnd;                       // a light or prox cycle ended
  logic        lightIrqSet, proxIrqSet;
  logic        lightCycleDone_next_w;

  // read mux: registers outside this block read as zero
  always_comb begin
    unique case (pointer_reg)
      `OFS_FUNCTION_ENABLE:  readData = enable_reg;
      `OFS_LIGHT_INTEG_TIME: readData = integ_reg;
      default:               readData = 8'h00;
    endcase
  end

  // ----------------------------------------
  // command decode and register writes
  // ----------------------------------------
  always_comb begin
    enable_next = enable_reg;
    integ_next  = integ_reg;
    pointer_next = pointer_reg;
    xfer_next   = xfer_reg;
    clearProx   = 1'b0;
    clearLight  = 1'b0;
    if (byteValid && byteFirst) begin
      // host marks command bytes with the select bit
      if (byteData[`CMD_SELECT_BIT]) begin
        if (xfer_type_t'(byteData[`CMD_TYPE_HI:`CMD_TYPE_LO]) == XFER_SPECIAL) begin
          // low field is a function code, pointer untouched
          unique case (byteData[`CMD_ADDR_HI:0])
            `SF_CLEAR_PROX:  clearProx = 1'b1;
            `SF_CLEAR_LIGHT: clearLight = 1'b1;
            `SF_CLEAR_BOTH: begin
              clearProx  = 1'b1;
              clearLight = 1'b1;
            end
            default: ;  // no action, reserved codes also ignored
          endcase
        end else begin
          pointer_next = byteData[`CMD_ADDR_HI:0];
          xfer_next    = xfer_type_t'(byteData[`CMD_TYPE_HI:`CMD_TYPE_LO]);
        end
      end
    end else if (byteValid) begin
      unique case (pointer_reg)
        `OFS_FUNCTION_ENABLE:  enable_next = byteData;
        `OFS_LIGHT_INTEG_TIME: integ_next  = byteData;
        default: ;
      endcase
    end
    // data bytes advance only in auto-increment mode
    if (((byteValid && !byteFirst) || readLoad) && xfer_reg == XFER_AUTOINC) begin
      pointer_next = pointer_reg + 5'h01;
    end
    // sleep after interrupt drops the oscillator bit
    if (cycleEnd && enable_reg[`EN_SLEEP_AFTER_IRQ] &&
        (lightIrqSet || proxIrqSet || lightPend_reg || proxPend_reg)) begin
      enable_next[`EN_OSCILLATOR] = 1'b0;
    end
  end

  // ----------------------------------------
  // interrupt flags: set wins over clear
  // ----------------------------------------
  always_comb begin
    lightIrqSet    = lightCycleDone_next_w & lightOutOfRange & enable_reg[`EN_LIGHT_IRQ_MASK];
    proxIrqSet     = proxCycleDone & proxOutOfRange & enable_reg[`EN_PROX_IRQ_MASK];
    cycleEnd       = lightCycleDone_next_w | proxCycleDone;
    // clear is a one-shot strobe, nothing stored
    proxPend_next  = (proxPend_reg & ~clearProx) | proxIrqSet;
    lightPend_next = (lightPend_reg & ~clearLight) | lightIrqSet;
    irq_next       = proxPend_next | lightPend_next;
    // nothing runs without the oscillator
    gated_next[0]  = enable_next[`EN_OSCILLATOR];
    gated_next[1]  = enable_next[`EN_OSCILLATOR] & enable_next[`EN_LIGHT_CONVERTER];
    gated_next[2]  = enable_next[`EN_OSCILLATOR] & enable_next[`EN_PROX_FUNCTION];
    gated_next[3]  = enable_next[`EN_OSCILLATOR] & enable_next[`EN_WAIT_TIMER];
  end

  // ----------------------------------------
  // light integration timing
  // ----------------------------------------
  logic [19:0] prescale_reg, prescale_next;    // cycles within one step
  logic [8:0]  steps_reg, steps_next;          // steps done this cycle
  logic [16:0] accum_reg, accum_next;          // running count
  logic [15:0] result_reg, result_next;
  logic        done_reg;
  logic [8:0]  stepTotal;
  logic [10:0] stepCounts;
  logic [17:0] sum;

  assign stepTotal = 9'(`TOTAL_STEP_BASE) - {1'b0, integ_reg};

  always_comb begin
    prescale_next         = prescale_reg;
    steps_next            = steps_reg;
    accum_next            = accum_reg;
    result_next           = result_reg;
    lightCycleDone_next_w = 1'b0;
    // one step never yields more than the per-step limit
    stepCounts = (lightStepCounts > 11'(`STEP_COUNT_LIMIT)) ? 11'(`STEP_COUNT_LIMIT) : lightStepCounts;
    sum        = {1'b0, accum_reg} + {7'h00, stepCounts};
    if (!gated_reg[1]) begin
      prescale_next = 20'h00000;
      steps_next    = 9'h000;
      accum_next    = 17'h00000;
    end else if (prescale_reg == 20'(STEP_CYCLES - 1)) begin
      prescale_next = 20'h00000;
      accum_next    = (sum > 18'(`RESULT_SATURATE)) ? 17'(`RESULT_SATURATE) : sum[16:0];
      if (steps_reg + 9'h001 >= stepTotal) begin
        // last step: publish and restart the next cycle
        lightCycleDone_next_w = 1'b1;
        result_next = (sum > 18'(`RESULT_SATURATE)) ? 16'(`RESULT_SATURATE) : sum[15:0];
        steps_next  = 9'h000;
        accum_next  = 17'h00000;
      end else begin
        steps_next = steps_reg + 9'h001;
      end
    end else begin
      prescale_next = prescale_reg + 20'h00001;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg    <= `RST_FUNCTION_ENABLE;
      integ_reg     <= `RST_LIGHT_INTEG_TIME;
      pointer_reg   <= 5'h00;
      xfer_reg      <= XFER_REPEAT;
      proxPend_reg  <= 1'b0;
      lightPend_reg <= 1'b0;
      irq_reg       <= 1'b0;
      gated_reg     <= 4'h0;
      prescale_reg  <= 20'h00000;
      steps_reg     <= 9'h000;
      accum_reg     <= 17'h00000;
      result_reg    <= 16'h0000;
      done_reg      <= 1'b0;
    end else begin
      enable_reg    <= enable_next;
      integ_reg     <= integ_next;
      pointer_reg   <= pointer_next;
      xfer_reg      <= xfer_next;
      proxPend_reg  <= proxPend_next;
      lightPend_reg <= lightPend_next;
      irq_reg       <= irq_next;
      gated_reg     <= gated_next;
      prescale_reg  <= prescale_next;
      steps_reg     <= steps_next;
      accum_reg     <= accum_next;
      result_reg    <= result_next;
      done_reg      <= lightCycleDone_next_w;
    end
  end

  // outputs straight from flops
  assign oscillatorOn     = gated_reg[0];
  assign lightConverterOn = gated_reg[1];
  assign proxFunctionOn   = gated_reg[2];
  assign waitTimerOn      = gated_reg[3];
  assign lightCycleDone   = done_reg;
  assign lightResult      = result_reg;
  assign proxIrqPending   = proxPend_reg;
  assign lightIrqPending  = lightPend_reg;
  assign irqActive        = irq_reg;

endmodule : sensor_command_enable_ctrl

// ---- design/serial_target.sv ----
// two-wire serial target: sampled clock, byte receive and transmit
`timescale 1ns/1ps
module serial_target
  import sensor_cmd_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2a  // arbitrary bus address
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // serial pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOe_n,
  // byte side
  output logic            byteValid,
  output logic            byteFirst,
  output logic [7:0]      byteData,
  output logic            readLoad,
  input  wire logic [7:0] readData
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  ser_state_t  state_reg, state_next;         // transfer phase
  logic [2:0]  sclSync_reg, sclSync_next;     // two sync stages plus history
  logic [2:0]  sdaSync_reg, sdaSync_next;
  logic [7:0]  shift_reg, shift_next;         // in or out byte
  logic [2:0]  bitCnt_reg, bitCnt_next;
  logic        gotByte_reg, gotByte_next;     // eight bits seen
  logic        isRead_reg, isRead_next;
  logic        first_reg, first_next;         // next write byte is the command
  logic        oeN_reg, oeN_next;             // low while pulling sda down
  logic        valid_reg, valid_next;
  logic        load_reg, load_next;
  logic        sclNow, sclOld, sdaNow, sdaOld;
  logic        rise, fall, startSeen, stopSeen;

  // stage 0 feeds only stage 1; edges use stages 1 and 2
  assign sclNow    = sclSync_reg[1];
  assign sclOld    = sclSync_reg[2];
  assign sdaNow    = sdaSync_reg[1];
  assign sdaOld    = sdaSync_reg[2];
  assign rise      = sclNow & ~sclOld;
  assign fall      = ~sclNow & sclOld;
  assign startSeen = sclNow & sclOld & sdaOld & ~sdaNow;
  assign stopSeen  = sclNow & sclOld & ~sdaOld & sdaNow;

  assign sdaOe_n   = oeN_reg;
  assign byteValid = valid_reg;
  assign byteFirst = first_reg;
  assign byteData  = shift_reg;
  assign readLoad  = load_reg;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    state_next   = state_reg;
    sclSync_next = {sclSync_reg[1:0], sclIn};
    sdaSync_next = {sdaSync_reg[1:0], sdaIn};
    shift_next   = shift_reg;
    bitCnt_next  = bitCnt_reg;
    gotByte_next = gotByte_reg;
    isRead_next  = isRead_reg;
    first_next   = first_reg;
    oeN_next     = oeN_reg;
    valid_next   = 1'b0;
    load_next    = 1'b0;
    if (startSeen) begin
      // repeated start restarts addressing, pointer kept by the controller
      state_next   = SER_ADDR;
      bitCnt_next  = 3'h0;
      gotByte_next = 1'b0;
      oeN_next     = 1'b1;
    end else if (stopSeen) begin
      state_next = SER_IDLE;
      oeN_next   = 1'b1;
    end else begin
      unique case (state_reg)
        SER_IDLE: begin
          oeN_next = 1'b1;
        end
        SER_ADDR, SER_WRBYTE: begin
          if (rise) begin
            shift_next   = {shift_reg[6:0], sdaNow};
            bitCnt_next  = bitCnt_reg + 3'h1;
            gotByte_next = (bitCnt_reg == 3'h7);
          end else if (fall && gotByte_reg) begin
            gotByte_next = 1'b0;
            if (state_reg == SER_WRBYTE) begin
              valid_next = 1'b1;
              oeN_next   = 1'b0;  // acknowledge every written byte
              state_next = SER_ACK;
            end else if (shift_reg[7:1] == TARGET_ADDR) begin
              isRead_next = shift_reg[0];
              first_next  = ~shift_reg[0];
              oeN_next    = 1'b0;
              state_next  = SER_ACK;
            end else begin
              state_next = SER_IDLE;  // not ours: stay off the bus
            end
          end
        end
        SER_ACK: begin
          if (valid_reg) begin
            first_next = 1'b0;
          end
          if (fall) begin
            bitCnt_next = 3'h0;
            if (isRead_reg) begin
              // readData is valid now; in auto-increment mode the controller advances pointer after
              load_next  = 1'b1;
              shift_next = {readData[6:0], 1'b0};
              oeN_next   = readData[7];
              state_next = SER_RDBYTE;
            end else begin
              oeN_next   = 1'b1;
              state_next = SER_WRBYTE;
            end
          end
        end
        SER_RDBYTE: begin
          if (rise) begin
            bitCnt_next  = bitCnt_reg + 3'h1;
            gotByte_next = (bitCnt_reg == 3'h7);
          end else if (fall) begin
            if (gotByte_reg) begin
              gotByte_next = 1'b0;
              oeN_next     = 1'b1;  // release for the controller's ack
              state_next   = SER_RDACK;
            end else begin
              oeN_next   = shift_reg[7];
              shift_next = {shift_reg[6:0], 1'b0};
            end
          end
        end
        SER_RDACK: begin
          if (rise) begin
            // a high level here is a not-acknowledge: stop sending
            state_next = sdaNow ? SER_IDLE : SER_ACK;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= SER_IDLE;
      sclSync_reg <= 3'h7;
      sdaSync_reg <= 3'h7;
      shift_reg   <= 8'h00;
      bitCnt_reg  <= 3'h0;
      gotByte_reg <= 1'b0;
      isRead_reg  <= 1'b0;
      first_reg   <= 1'b0;
      oeN_reg     <= 1'b1;
      valid_reg   <= 1'b0;
      load_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      sclSync_reg <= sclSync_next;
      sdaSync_reg <= sdaSync_next;
      shift_reg   <= shift_next;
      bitCnt_reg  <= bitCnt_next;
      gotByte_reg <= gotByte_next;
      isRead_reg  <= isRead_next;
      first_reg   <= first_next;
      oeN_reg     <= oeN_next;
      valid_reg   <= valid_next;
      load_reg    <= load_next;
    end
  end

endmodule : serial_target

// ---- verification/sensor_ctrl_assertions.sv ----
// assertion checker for the sensor command and enable controller
`timescale 1ns/1ps
module sensor_ctrl_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // proximity events
  input wire logic        proxCycleDone,
  input wire logic        proxOutOfRange,
  // function controls
  input wire logic        oscillatorOn,
  input wire logic        lightConverterOn,
  input wire logic        proxFunctionOn,
  input wire logic        waitTimerOn,
  // results and interrupts
  input wire logic        lightCycleDone,
  input wire logic [15:0] lightResult,
  input wire logic        proxIrqPending,
  input wire logic        lightIrqPending,
  input wire logic        irqActive
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // proximity cycle that ended out of range
  sequence proxHit;
    proxCycleDone && proxOutOfRange;
  endsequence
  // converter held off two cycles, so no cycle may still finish
  sequence convIdle;
    !lightConverterOn [*2];
  endsequence
  chk_conv_osc: assert property (lightConverterOn |-> oscillatorOn)
    else $error("light converter on without oscillator");
  chk_prox_osc: assert property (proxFunctionOn |-> oscillatorOn)
    else $error("proximity on without oscillator");
  chk_wait_osc: assert property (waitTimerOn |-> oscillatorOn)
    else $error("wait timer on without oscillator");
  chk_irq_or: assert property (irqActive == (proxIrqPending || lightIrqPending))
    else $error("interrupt line differs from pending flags");
  chk_prox_cause: assert property ($rose(proxIrqPending) |-> $past(proxCycleDone && proxOutOfRange))
    else $error("proximity pending without an event");
  chk_prox_hold: assert property (proxHit ##0 proxIrqPending |=> proxIrqPending)
    else $error("proximity pending lost during an event");
  chk_light_cause: assert property ($rose(lightIrqPending) |-> lightCycleDone || $past(lightCycleDone))
    else $error("light pending without a cycle end");
  chk_result_done: assert property ($changed(lightResult) |-> lightCycleDone)
    else $error("light result changed outside a cycle end");
  chk_done_pulse: assert property (lightCycleDone |=> !lightCycleDone)
    else $error("cycle end pulse longer than one clock");
  chk_idle_nodone: assert property (convIdle |=> !lightCycleDone)
    else $error("cycle end while converter off");
endmodule : sensor_ctrl_checker
bind sensor_command_enable_ctrl sensor_ctrl_checker checkInst (.clk, .rst_n, .proxCycleDone, .proxOutOfRange,
  .oscillatorOn, .lightConverterOn, .proxFunctionOn, .waitTimerOn, .lightCycleDone, .lightResult,
  .proxIrqPending, .lightIrqPending, .irqActive);

// ---- verification/serial_host.sv ----
// host model that drives the two-wire link as bus controller
`timescale 1ns/1ps
module serial_host #(
  parameter logic [6:0] ADDR = 7'h2a  // target address, arbitrary
) (
  // clock
  input  wire logic clk,
  // link pins
  output logic      scl,
  output logic      hostOe_n,
  input  wire logic sdaLine
);
  // ----------------------------------------
  // bus cycles, 8 clocks per bit
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    hostOe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // data moves one clock after the fall so it never looks like start or stop
  task automatic bitx(input logic b, output logic r);
    tick(1);
    hostOe_n = b;
    tick(3);
    scl = 1'b1;
    tick(4);
    r = sdaLine;
    scl = 1'b0;
  endtask : bitx
  task automatic sendByte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, nak);  // released for the acknowledge
  endtask : sendByte
  task automatic recvByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);  // no acknowledge on the last byte
  endtask : recvByte
  // address, command, writes, then repeated start and reads
  task automatic frame(input logic [7:0] cmd, input int nw, input logic [15:0] wd, input int nr,
                       output logic [15:0] rd, output logic nak);
    logic a;
    nak = 1'b0;
    rd = 16'h0000;
    tick(4);
    hostOe_n = 1'b0;
    tick(4);
    scl = 1'b0;
    sendByte({ADDR, 1'b0}, a);
    nak |= a;
    sendByte({1'b1, cmd[6:0]}, a);
    nak |= a;
    for (int i = 0; i < nw; i++) begin
      sendByte(wd[i*8+:8], a);
      nak |= a;
    end
    if (nr > 0) begin
      tick(1);
      hostOe_n = 1'b1;
      tick(7);  // wait out the target's acknowledge release
      scl = 1'b1;
      tick(4);
      hostOe_n = 1'b0;
      tick(4);
      scl = 1'b0;
      sendByte({ADDR, 1'b1}, a);
      nak |= a;
      for (int i = 0; i < nr; i++) recvByte(i == nr - 1, rd[i*8+:8]);
    end
    tick(1);
    hostOe_n = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    hostOe_n = 1'b1;
    tick(4);
  endtask : frame
endmodule : serial_host

// ---- verification/testbench.sv ----
// self-checking bench for the sensor command and enable controller
`timescale 1ns/1ps
module testbench;
  import sensor_cmd_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int STEPS = 8;  // short step keeps cycles brief
  logic        clk, rst_n, scl, hostOe_n, sdaOe_n;
  wire         sdaLine = hostOe_n & sdaOe_n;  // pull-up, either side pulls low
  logic [10:0] stepCounts;
  logic        lightOor, proxDone, proxOor, oscOn, convOn, proxOn, waitOn, lightDone, proxIrq, lightIrq, irqAct;
  logic [15:0] lightRes, rd;
  logic        nak;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0;
  sensor_command_enable_ctrl #(.STEP_CYCLES(STEPS)) uut (.clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOe_n(sdaOe_n), .lightStepCounts(stepCounts), .lightOutOfRange(lightOor), .proxCycleDone(proxDone),
    .proxOutOfRange(proxOor), .oscillatorOn(oscOn), .lightConverterOn(convOn), .proxFunctionOn(proxOn),
    .waitTimerOn(waitOn), .lightCycleDone(lightDone), .lightResult(lightRes), .proxIrqPending(proxIrq),
    .lightIrqPending(lightIrq), .irqActive(irqAct));
  serial_host host (.clk(clk), .scl(scl), .hostOe_n(hostOe_n), .sdaLine(sdaLine));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, far above the fewer than 8000 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic xfer(input logic [7:0] cmd, input int nw, input logic [15:0] wd, input int nr);
    host.frame(cmd, nw, wd, nr, rd, nak);
    check("acknowledge", 16'h0000, {15'h0, nak});
  endtask : xfer
  task automatic pulseProx();
    @(negedge clk);
    proxDone = 1'b1;
    proxOor = 1'b1;
    @(negedge clk);
    proxDone = 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulseProx
  task automatic waitDone(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lightDone !== 1'b1 && n < 3000);
  endtask : waitDone
  task automatic raiseBoth();
    int n;
    pulseProx();
    lightOor = 1'b1;
    waitDone(n);
    @(negedge clk);
    lightOor = 1'b0;
    repeat (2) @(negedge clk);
  endtask : raiseBoth
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("idle outputs", 16'h0001, {7'h0, oscOn, convOn, proxOn, waitOn, lightDone, proxIrq, lightIrq, irqAct,
          sdaOe_n});
    xfer(8'ha0, 0, 16'h0000, 2);
    check("reset registers", 16'hff00, rd);
    xfer(8'h81, 0, 16'h0000, 2);
    check("repeat read", 16'hffff, rd);
    xfer(8'h9f, 0, 16'h0000, 1);
    check("unmapped read", 16'h0000, rd);
    $display("reset test done");
  endtask : t_reset
  task automatic t_enable();
    logic [7:0] v [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h0e};
    foreach (v[i]) begin
      xfer(8'h80, 1, {9'h0, v[i][6:0]}, 0);
      check("controls", {12'h0, v[i][0] ? v[i][3:0] : 4'h0}, {12'h0, waitOn, proxOn, convOn, oscOn});
      xfer(8'h80, 0, 16'h0000, 1);
      check("enable readback", {8'h0, v[i]}, rd);
    end
    $display("enable test done");
  endtask : t_enable
  task automatic t_light();
    int n;
    stepCounts = 11'h401;  // above the per-step ceiling
    xfer(8'ha0, 2, 16'hfe03, 0);
    waitDone(n);
    waitDone(n);
    check("two-step period", 16'h0010, n[15:0]);
    check("clamped result", 16'h0800, lightRes);
    xfer(8'h81, 1, 16'h00c0, 0);
    waitDone(n);
    waitDone(n);
    check("64-step period", 16'h0200, n[15:0]);
    check("saturated result", 16'hffff, lightRes);
    $display("light test done");
  endtask : t_light
  task automatic t_irq();
    logic [7:0] code [4] = '{8'he0, 8'he5, 8'he6, 8'he7};
    logic [1:0] left [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
    xfer(8'ha0, 2, 16'hff37, 0);
    foreach (code[i]) begin
      raiseBoth();
      check("pending", 16'h0007, {13'h0, proxIrq, lightIrq, irqAct});
      xfer(code[i], 0, 16'h0000, 0);
      check("after special", {14'h0, left[i]}, {14'h0, proxIrq, lightIrq});
    end
    xfer(8'h80, 1, 16'h0007, 0);
    raiseBoth();
    check("masked", 16'h0000, {14'h0, proxIrq, lightIrq});
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_sleep();
    xfer(8'h80, 1, 16'h0065, 0);
    pulseProx();
    check("asleep", 16'h0000, {14'h0, oscOn, proxOn});
    xfer(8'h80, 0, 16'h0000, 1);
    check("enable after sleep", 16'h0064, rd);
    $display("sleep test done");
  endtask : t_sleep
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    rst_n = 1'b0;
    {stepCounts, lightOor, proxDone, proxOor} = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_enable();
    t_light();
    t_irq();
    t_sleep();
    conclude();
  end
endmodule : testbench
